/* File: core/sol_pkg.sv */
// constants shared by the system option latch bank
`default_nettype none
package sol_pkg;
  // register indices as printed, byte address is four times the index
  localparam logic [7:0] SOL_OPTA_IDX = 8'h1D;
  localparam logic [7:0] SOL_OPTB_IDX = 8'h1F;
  localparam int SOL_ADDR_W = 12;
  localparam logic [11:0] SOL_OPTA_ADDR = {2'h0, SOL_OPTA_IDX, 2'h0};
  localparam logic [11:0] SOL_OPTB_ADDR = {2'h0, SOL_OPTB_IDX, 2'h0};
  // system_options_a field positions
  localparam int SOL_A_WDOG_DIS = 0;
  localparam int SOL_A_STOP_EN = 1;
  localparam int SOL_A_SHORT_STOP_RECOVERY_SEL = 2;
  localparam logic [7:0] SOL_A_WMASK = 8'h07;
  // system_options_b field positions
  localparam int SOL_B_RC_OFF = 0;
  localparam int SOL_B_XT_KEEP = 1;
  localparam int SOL_B_DIV_BYP = 2;
  localparam int SOL_B_PC_LO = 3;
  localparam int SOL_B_PC_HI = 4;
  localparam int SOL_B_RANGE_LO = 6;
  localparam int SOL_B_RANGE_HI = 7;
  localparam logic [7:0] SOL_B_WMASK = 8'h1F;
  // reset values
  localparam logic [7:0] SOL_OPT_RST = 8'h00;
  localparam logic [1:0] SOL_RANGE_RST = 2'h0;
  // supply monitor range codes
  localparam logic [1:0] SOL_RANGE_2V5 = 2'h0;
  localparam logic [1:0] SOL_RANGE_3V = 2'h1;
  localparam logic [1:0] SOL_RANGE_5V = 2'h2;
  localparam logic [1:0] SOL_RANGE_RSV = 2'h3;
  // stop recovery lengths in internal rc clock ticks
  localparam int SOL_REC_SHORT = 32;
  localparam int SOL_REC_LONG = 4096;
  localparam int SOL_REC_CNT_W = 13;
  // port c nibble width
  localparam int SOL_PC_NIB = 4;
endpackage
`default_nettype wire

/* File: core/sol_option_bank.sv */
// write-once system option latches with apb access and option decode
//
// Functional notes
// - with short recovery selected stop recovery lasts 32 rc clock ticks, otherwise 4096.
// - leaving stop through the reset pin always uses the long recovery.
// - the stop instruction runs when enabled and is an illegal opcode when not.
// - the watchdog disable bit turns the watchdog off when set.
// - the rc oscillator halts in stop when its stop-off bit is set; reset clears it.
// - the crystal oscillator keeps running in stop when its keep bit is set; reset clears it.
// - with pll not selected the bypass bit makes clockgen output equal the crystal clock.
// - with pll selected the bypass bit is ignored and the vco is divided by two.
// - the upper port c nibble drives frontplanes 23 to 26 when its select bit is set.
// - the lower port c nibble drives frontplanes 19 to 22 when its select bit is set.
// - the two-bit range picks 3V (01) or 5V (10); 00 and 11 are reserved.
// - only the first write to each option register after reset is taken; reads always work.
// - the range field is writable once after power-on reset and survives other resets.
// - the two option registers sit at 001D and 001F.
`default_nettype none
module sol_option_bank #(
  parameter int SHORT_TICKS = sol_pkg::SOL_REC_SHORT,
  parameter int LONG_TICKS = sol_pkg::SOL_REC_LONG
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sol_pkg::SOL_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_clk_tick,
  input wire logic stop_exit_req,
  input wire logic stop_exit_by_pin,
  input wire logic stop_instr_seen,
  input wire logic in_stop,
  input wire logic pll_clock_select,
  output logic stop_recovering,
  output logic stop_recovery_done,
  output logic stop_enter,
  output logic illegal_opcode,
  output logic watchdog_run,
  output logic rc_osc_run,
  output logic xtal_osc_run,
  output logic cg_src_pll,
  output logic cg_div2_en,
  output logic [7:0] portc_fp_sel,
  output logic lvm_mode_3v,
  output logic lvm_mode_5v,
  output logic lvm_mode_rsv
);
  logic [7:0] opt_a_q;
  logic [7:0] opt_b_q;
  logic [1:0] range_q;
  logic wr_done_a_q;
  logic wr_done_b_q;
  logic range_lock_q;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  logic hit_a;
  logic hit_b;
  logic wr_acc;
  logic wr_a;
  logic wr_b;
  logic rec_q;
  logic rec_long_q;
  logic rec_done_q;
  logic [sol_pkg::SOL_REC_CNT_W-1:0] rec_cnt_q;
  logic [sol_pkg::SOL_REC_CNT_W-1:0] rec_last;
  logic rec_end;
  logic stop_enter_q;
  logic illegal_q;
  logic wdog_run_q;
  logic rc_run_q;
  logic xt_run_q;
  logic cg_pll_q;
  logic cg_div2_q;
  logic [7:0] fp_sel_q;
  logic lvm_3v_q;
  logic lvm_5v_q;
  logic lvm_rsv_q;

  // address decode, registers one word each
  // option register map
  assign hit_a = (paddr == sol_pkg::SOL_OPTA_ADDR);
  assign hit_b = (paddr == sol_pkg::SOL_OPTB_ADDR);
  assign wr_acc = psel && penable && pready_q && pwrite;
  assign wr_a = wr_acc && hit_a;
  assign wr_b = wr_acc && hit_b;
  assign pready_d = psel && penable && !pready_q;

  // read mux, unused bits read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_a) begin
      rdata_d[7:0] = opt_a_q;
    end else if (hit_b) begin
      rdata_d[7:0] = opt_b_q;
      rdata_d[sol_pkg::SOL_B_RANGE_HI:sol_pkg::SOL_B_RANGE_LO] = range_q;
    end
  end

  // apb answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pready_d && !(hit_a || hit_b);
      if (pready_d && !pwrite) begin
        prdata_q <= rdata_d;
      end
    end
  end

  // system_options_a latch, first write wins
  // write once after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_a_q <= sol_pkg::SOL_OPT_RST;
      wr_done_a_q <= 1'b0;
    end else if (wr_a && !wr_done_a_q) begin
      opt_a_q <= pwdata[7:0] & sol_pkg::SOL_A_WMASK;
      wr_done_a_q <= 1'b1;
    end
  end

  // system_options_b latch, first write wins
  // write once after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_b_q <= sol_pkg::SOL_OPT_RST;
      wr_done_b_q <= 1'b0;
    end else if (wr_b && !wr_done_b_q) begin
      opt_b_q <= pwdata[7:0] & sol_pkg::SOL_B_WMASK;
      wr_done_b_q <= 1'b1;
    end
  end

  // range field lives on power-on reset only
  // once per power-on
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      range_q <= sol_pkg::SOL_RANGE_RST;
      range_lock_q <= 1'b0;
    end else if (wr_b && !range_lock_q) begin
      range_q <= pwdata[sol_pkg::SOL_B_RANGE_HI:sol_pkg::SOL_B_RANGE_LO];
      range_lock_q <= 1'b1;
    end
  end

  // last tick index of the running recovery
  // short or long length
  assign rec_last = rec_long_q ? sol_pkg::SOL_REC_CNT_W'(LONG_TICKS - 1)
                               : sol_pkg::SOL_REC_CNT_W'(SHORT_TICKS - 1);
  assign rec_end = rec_q && rc_clk_tick && (rec_cnt_q == rec_last);

  // stop recovery counter on rc clock ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_q <= 1'b0;
      rec_long_q <= 1'b1;
      rec_cnt_q <= '0;
      rec_done_q <= 1'b0;
    end else begin
      rec_done_q <= rec_end;
      if (stop_exit_req) begin
        rec_q <= 1'b1;
        rec_long_q <= stop_exit_by_pin || !opt_a_q[sol_pkg::SOL_A_SHORT_STOP_RECOVERY_SEL];
        rec_cnt_q <= '0;
      end else if (rec_end) begin
        rec_q <= 1'b0;
        rec_cnt_q <= '0;
      end else if (rec_q && rc_clk_tick) begin
        rec_cnt_q <= rec_cnt_q + 1'b1;
      end
    end
  end

  // stop instruction legality
  // stop or illegal opcode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_enter_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      stop_enter_q <= stop_instr_seen && opt_a_q[sol_pkg::SOL_A_STOP_EN];
      illegal_q <= stop_instr_seen && !opt_a_q[sol_pkg::SOL_A_STOP_EN];
    end
  end

  // watchdog and oscillator run controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_run_q <= 1'b1;
      rc_run_q <= 1'b1;
      xt_run_q <= 1'b1;
    end else begin
      wdog_run_q <= !opt_a_q[sol_pkg::SOL_A_WDOG_DIS];
      rc_run_q <= !(in_stop && opt_b_q[sol_pkg::SOL_B_RC_OFF]);
      xt_run_q <= !in_stop || opt_b_q[sol_pkg::SOL_B_XT_KEEP];
    end
  end

  // clock generator source and divider select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cg_pll_q <= 1'b0;
      cg_div2_q <= 1'b1;
    end else begin
      cg_pll_q <= pll_clock_select;
      cg_div2_q <= pll_clock_select || !opt_b_q[sol_pkg::SOL_B_DIV_BYP];
    end
  end

  // per pin frontplane select on port c
  genvar gi;
  generate
    for (gi = 0; gi < 2 * sol_pkg::SOL_PC_NIB; gi++) begin : g_fp
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fp_sel_q[gi] <= 1'b0;
        end else if (gi < sol_pkg::SOL_PC_NIB) begin
          fp_sel_q[gi] <= opt_b_q[sol_pkg::SOL_B_PC_LO];
        end else begin
          fp_sel_q[gi] <= opt_b_q[sol_pkg::SOL_B_PC_HI];
        end
      end
    end
  endgenerate

  // supply monitor mode decode
  // range code decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvm_3v_q <= 1'b0;
      lvm_5v_q <= 1'b0;
      lvm_rsv_q <= 1'b1;
    end else begin
      lvm_3v_q <= (range_q == sol_pkg::SOL_RANGE_3V);
      lvm_5v_q <= (range_q == sol_pkg::SOL_RANGE_5V);
      lvm_rsv_q <= (range_q == sol_pkg::SOL_RANGE_2V5) || (range_q == sol_pkg::SOL_RANGE_RSV);
    end
  end

  // outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign stop_recovering = rec_q;
  assign stop_recovery_done = rec_done_q;
  assign stop_enter = stop_enter_q;
  assign illegal_opcode = illegal_q;
  assign watchdog_run = wdog_run_q;
  assign rc_osc_run = rc_run_q;
  assign xtal_osc_run = xt_run_q;
  assign cg_src_pll = cg_pll_q;
  assign cg_div2_en = cg_div2_q;
  assign portc_fp_sel = fp_sel_q;
  assign lvm_mode_3v = lvm_3v_q;
  assign lvm_mode_5v = lvm_5v_q;
  assign lvm_mode_rsv = lvm_rsv_q;

  // checks on the design's own behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence pin_exit_s;
    stop_exit_req && stop_exit_by_pin;
  endsequence

  sequence long_start_s;
    rec_q && rec_long_q && (rec_cnt_q == '0);
  endsequence

  sequence short_exit_s;
    stop_exit_req && !stop_exit_by_pin && opt_a_q[sol_pkg::SOL_A_SHORT_STOP_RECOVERY_SEL];
  endsequence

  apb_answer_a: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer not one cycle");
  opta_once_a: assert property (wr_a && wr_done_a_q |=> $stable(opt_a_q))
    else $error("options a changed after first write");
  optb_first_a: assert property (wr_b && !wr_done_b_q
      |=> opt_b_q == ($past(pwdata[7:0]) & sol_pkg::SOL_B_WMASK) && wr_done_b_q)
    else $error("options b first write lost");
  range_lock_a: assert property (@(posedge pclk) disable iff (!por_n)
      range_lock_q && wr_b |=> $stable(range_q))
    else $error("range changed after lock");
  range_first_a: assert property (wr_b && !range_lock_q
      |=> range_q == $past(pwdata[sol_pkg::SOL_B_RANGE_HI:sol_pkg::SOL_B_RANGE_LO]))
    else $error("range first write lost");
  pin_long_a: assert property (pin_exit_s |=> long_start_s)
    else $error("pin exit not long recovery");
  short_len_a: assert property (short_exit_s |=> rec_q && !rec_long_q)
    else $error("short recovery not selected");
  rec_finish_a: assert property (rec_end && !stop_exit_req |=> !rec_q && rec_done_q)
    else $error("recovery did not end at its last tick");
  rec_count_a: assert property (rec_q && rc_clk_tick && !rec_end && !stop_exit_req
      |=> rec_cnt_q == $past(rec_cnt_q) + 1'b1)
    else $error("recovery counter missed a tick");
  stop_illegal_a: assert property (stop_instr_seen && !opt_a_q[sol_pkg::SOL_A_STOP_EN]
      |=> illegal_opcode && !stop_enter)
    else $error("disabled stop not illegal");
  stop_legal_a: assert property (stop_instr_seen && opt_a_q[sol_pkg::SOL_A_STOP_EN]
      |=> stop_enter && !illegal_opcode)
    else $error("enabled stop not taken");
  wdog_state_a: assert property (##1 watchdog_run != $past(opt_a_q[sol_pkg::SOL_A_WDOG_DIS]))
    else $error("watchdog run mismatch");
  // sampled reset keeps the release edge, where outputs still show reset values, out
  pll_div_a: assert property (presetn && pll_clock_select |=> cg_div2_en && cg_src_pll)
    else $error("pll path not divided");
  fp_nibble_a: assert property (##1 portc_fp_sel
      == {{4{$past(opt_b_q[sol_pkg::SOL_B_PC_HI])}}, {4{$past(opt_b_q[sol_pkg::SOL_B_PC_LO])}}})
    else $error("frontplane select mismatch");

  // oscillator, divider and monitor decode checks
  rc_halt_a: assert property (in_stop && opt_b_q[sol_pkg::SOL_B_RC_OFF] |=> !rc_osc_run)
    else $error("rc osc not halted in stop");
  xtal_stop_a: assert property (presetn && in_stop && !opt_b_q[sol_pkg::SOL_B_XT_KEEP]
      |=> !xtal_osc_run)
    else $error("crystal not stopped in stop");
  div_bypass_a: assert property (!pll_clock_select && opt_b_q[sol_pkg::SOL_B_DIV_BYP]
      |=> !cg_div2_en)
    else $error("divider not bypassed");
  lvm_5v_a: assert property (presetn && range_q == sol_pkg::SOL_RANGE_5V
      |=> lvm_mode_5v && !lvm_mode_3v && !lvm_mode_rsv)
    else $error("5v range decode wrong");
  lvm_3v_a: assert property (presetn && range_q == sol_pkg::SOL_RANGE_3V
      |=> lvm_mode_3v && !lvm_mode_5v && !lvm_mode_rsv)
    else $error("3v range decode wrong");
endmodule
`default_nettype wire

/* File: sim/sol_option_bank_test.sv */
// self-checking bench for the write-once system option latch bank
`default_nettype none
module sol_option_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LONG_N = 64;
  localparam int SHORT_N = 32;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic por_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, stop_recovering, stop_recovery_done, stop_enter, illegal_opcode;
  logic watchdog_run, rc_osc_run, xtal_osc_run, cg_src_pll, cg_div2_en;
  logic lvm_mode_3v, lvm_mode_5v, lvm_mode_rsv;
  logic [7:0] portc_fp_sel;
  logic rc_clk_tick = 1'b0;
  logic stop_exit_req = 1'b0;
  logic stop_exit_by_pin = 1'b0;
  logic stop_instr_seen = 1'b0;
  logic in_stop = 1'b0;
  logic pll_clock_select = 1'b0;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  // clock at 100 ns period
  always #50 pclk = ~pclk;
  sol_option_bank #(.SHORT_TICKS(SHORT_N), .LONG_TICKS(LONG_N)) dut_u (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rc_clk_tick(rc_clk_tick), .stop_exit_req(stop_exit_req),
    .stop_exit_by_pin(stop_exit_by_pin), .stop_instr_seen(stop_instr_seen), .in_stop(in_stop),
    .pll_clock_select(pll_clock_select), .stop_recovering(stop_recovering),
    .stop_recovery_done(stop_recovery_done), .stop_enter(stop_enter),
    .illegal_opcode(illegal_opcode), .watchdog_run(watchdog_run), .rc_osc_run(rc_osc_run),
    .xtal_osc_run(xtal_osc_run), .cg_src_pll(cg_src_pll), .cg_div2_en(cg_div2_en),
    .portc_fp_sel(portc_fp_sel), .lvm_mode_3v(lvm_mode_3v), .lvm_mode_5v(lvm_mode_5v),
    .lvm_mode_rsv(lvm_mode_rsv));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                     input logic [31:0] exp, input logic exp_err);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk(32'(pready), 32'h1);
    chk(32'(pslverr), 32'(exp_err));
    if (!wr) chk(prdata, exp);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stop_op(input logic legal);
    @(posedge pclk);
    stop_instr_seen <= 1'b1;
    @(posedge pclk);
    stop_instr_seen <= 1'b0;
    @(posedge pclk);
    chk(32'(stop_enter), 32'(legal));
    chk(32'(illegal_opcode), 32'(!legal));
  endtask
  // recovery must finish on exactly the n-th tick
  task automatic recover(input logic pin, input int n);
    @(posedge pclk);
    stop_exit_req <= 1'b1;
    stop_exit_by_pin <= pin;
    @(posedge pclk);
    stop_exit_req <= 1'b0;
    stop_exit_by_pin <= 1'b0;
    @(posedge pclk);
    chk(32'(stop_recovering), 32'h1);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rc_clk_tick <= 1'b1;
      @(posedge pclk);
      rc_clk_tick <= 1'b0;
      if (i == n - 1) chk(32'(stop_recovery_done), 32'h0);
      if (i == n - 1) chk(32'(stop_recovering), 32'h1);
    end
    @(posedge pclk);
    chk(32'(stop_recovery_done), 32'h1);
    chk(32'(stop_recovering), 32'h0);
  endtask
  task automatic do_reset(input logic power);
    @(posedge pclk);
    presetn <= 1'b0;
    por_n <= !power;
    step(10);
    presetn <= 1'b1;
    por_n <= 1'b1;
  endtask
  // main sequence
  initial begin
    logic [11:0] a_ad, b_ad;
    a_ad = sol_pkg::SOL_OPTA_ADDR;
    b_ad = sol_pkg::SOL_OPTB_ADDR;
    do_reset(1'b1);
    chk(32'(a_ad), 32'h74);
    chk(32'(b_ad), 32'h7C);
    apb(1'b0, a_ad, 32'h0, 32'h00, 1'b0);
    apb(1'b0, b_ad, 32'h0, 32'h00, 1'b0);
    chk(32'({watchdog_run, rc_osc_run, xtal_osc_run, cg_div2_en}), 32'hF);
    stop_op(1'b0);
    // crystal source with short recovery kept off
    recover(1'b0, LONG_N);
    apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h078, 32'hFF, 32'h0, 1'b1);
    apb(1'b1, a_ad, 32'h07, 32'h0, 1'b0);
    apb(1'b1, a_ad, 32'h00, 32'h0, 1'b0);
    apb(1'b0, a_ad, 32'h0, 32'h07, 1'b0);
    chk(32'(watchdog_run), 32'h0);
    stop_op(1'b1);
    recover(1'b0, SHORT_N);
    recover(1'b1, LONG_N);
    apb(1'b1, b_ad, 32'h5F, 32'h0, 1'b0);
    apb(1'b1, b_ad, 32'h00, 32'h0, 1'b0);
    apb(1'b0, b_ad, 32'h0, 32'h5F, 1'b0);
    chk(32'(portc_fp_sel), 32'hFF);
    chk(32'({cg_src_pll, cg_div2_en}), 32'h0);
    chk(32'({lvm_mode_3v, lvm_mode_5v, lvm_mode_rsv}), 32'h4);
    @(posedge pclk);
    pll_clock_select <= 1'b1;
    in_stop <= 1'b1;
    step(3);
    chk(32'({cg_src_pll, cg_div2_en}), 32'h3);
    chk(32'({rc_osc_run, xtal_osc_run}), 32'h1);
    // every range code, each after a power-on reset
    for (int c = 0; c < 4; c++) begin
      do_reset(1'b1);
      apb(1'b1, b_ad, {24'h0, 2'(c), 6'h00}, 32'h0, 1'b0);
      apb(1'b0, b_ad, 32'h0, {24'h0, 2'(c), 6'h00}, 1'b0);
      step(2);
      chk(32'(lvm_mode_3v), 32'(c == 1));
      chk(32'(lvm_mode_5v), 32'(c == 2));
      chk(32'(lvm_mode_rsv), 32'(c == 0 || c == 3));
      chk(32'({rc_osc_run, xtal_osc_run, portc_fp_sel}), 32'h200);
    end
    do_reset(1'b0);
    apb(1'b0, b_ad, 32'h0, 32'hC0, 1'b0);
    apb(1'b1, b_ad, 32'h1F, 32'h0, 1'b0);
    apb(1'b0, b_ad, 32'h0, 32'hDF, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
